// File: rtl/imf_formatter.sv
// Output unit formatter: sample pipeline, fields, byte stream and registers
`timescale 1ns/10ps
module imf_formatter #(
	parameter int SAMPLE_DIV = imf_pkg::SAMPLE_DIV
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic signed [imf_pkg::FIELD_W-1:0] gyro_sample,
	input wire logic signed [imf_pkg::FIELD_W-1:0] accel_sample,
	output logic sample_tick,
	output logic signed [imf_pkg::FIELD_W-1:0] gyro_field,
	output logic signed [imf_pkg::FIELD_W-1:0] accel_field,
	output logic field_valid,
	output logic [imf_pkg::BYTE_W-1:0] tx_byte,
	output logic tx_valid,
	output logic tx_first,
	input wire logic tx_ready
);
	import imf_pkg::*;

	localparam int DIV_W = $clog2(SAMPLE_DIV);

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic signed [FIELD_W-1:0] imf_scale(
		input logic signed [SUM_W-1:0] s, input logic [GAIN_W-1:0] k);
		logic signed [SUM_W+GAIN_W:0] p;
		p = s * $signed({1'b0, k});
		return p[GAIN_FRAC +: FIELD_W];
	endfunction : imf_scale

	function automatic logic signed [FIELD_W-1:0] imf_avg(
		input logic signed [SUM_W-1:0] s, input logic [LOG2N_W-1:0] sh);
		logic signed [SUM_W-1:0] q;
		q = s >>> sh;
		return q[FIELD_W-1:0];
	endfunction : imf_avg

	function automatic logic [BYTE_W-1:0] imf_byte(
		input logic [2*FIELD_W-1:0] f, input logic [2:0] idx);
		return f[(FRAME_BYTES - 1 - int'(idx)) * BYTE_W +: BYTE_W];
	endfunction : imf_byte

	// ****************************************
	// Registers and decoded controls
	// ****************************************
	logic [31:0] ctrl_r, gcomp_r;
	logic ovr_r;
	imf_gunit_e gunit;
	imf_aunit_e aunit;
	imf_lpf_e glpf, clpf;
	logic [LOG2N_W-1:0] log2n;
	logic signed [COEF_W-1:0] gb, gs;

	assign gunit = imf_gunit_e'(ctrl_r[CTRL_GUNIT_LSB +: 2]);
	assign aunit = imf_aunit_e'(ctrl_r[CTRL_AUNIT_LSB +: 2]);
	assign glpf = imf_lpf_e'(ctrl_r[CTRL_GLPF_LSB +: 2]);
	assign clpf = imf_lpf_e'(ctrl_r[CTRL_CLPF_LSB +: 2]);
	assign log2n = (ctrl_r[CTRL_LOG2N_LSB +: LOG2N_W] > LOG2N_MAX) ? LOG2N_MAX :
		ctrl_r[CTRL_LOG2N_LSB +: LOG2N_W];
	assign gb = $signed(gcomp_r[COEF_W-1:0]);
	assign gs = $signed(gcomp_r[GCOMP_SF_LSB +: COEF_W]);

	// ****************************************
	// Internal sample tick
	// ****************************************
	logic [DIV_W-1:0] div_cnt_r;
	logic t1_r, t2_r, t3_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_cnt_r <= '0;
			sample_tick <= 1'b0;
		end else begin
			sample_tick <= (div_cnt_r == DIV_W'(SAMPLE_DIV - 1)); // R14
			div_cnt_r <= (div_cnt_r == DIV_W'(SAMPLE_DIV - 1)) ? '0 : div_cnt_r + 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			t1_r <= 1'b0;
			t2_r <= 1'b0;
			t3_r <= 1'b0;
		end else begin
			t1_r <= sample_tick;
			t2_r <= t1_r;
			t3_r <= t2_r;
		end
	end

	// ****************************************
	// Sample capture and filters
	// ****************************************
	logic signed [FIELD_W-1:0] gyro_in_r, accel_in_r, gyro_f, accel_cf;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gyro_in_r <= '0;
			accel_in_r <= '0;
		end else if (sample_tick) begin
			gyro_in_r <= gyro_sample;
			accel_in_r <= accel_sample;
		end
	end

	imf_lpf #(.W(FIELD_W), .FRAC(LPF_FRAC)) u_gyro_lpf (
		.aclk(aclk), .aresetn(aresetn), .en(t1_r), .sel(glpf),
		.x(gyro_in_r), .y(gyro_f)
	);

	imf_lpf #(.W(FIELD_W), .FRAC(LPF_FRAC)) u_comp_lpf (
		.aclk(aclk), .aresetn(aresetn), .en(t1_r), .sel(clpf),
		.x(accel_in_r), .y(accel_cf)
	);

	// ****************************************
	// Gyro g-compensation
	// ****************************************
	logic signed [PROD_W-1:0] ga_w, bias_w, sf_w, corr_w;
	logic signed [FIELD_W-1:0] comp_r;

	always_comb begin
		ga_w = PROD_W'(gyro_f) * PROD_W'(accel_cf);
		bias_w = (PROD_W'(accel_cf) * PROD_W'(gb)) >>> COEF_FRAC;
		sf_w = ((ga_w >>> ONE_G_SHIFT) * PROD_W'(gs)) >>> COEF_FRAC;
		corr_w = PROD_W'(gyro_f); // R4
		if (ctrl_r[CTRL_BIAS_BIT]) begin
			corr_w = corr_w - bias_w; // R8
		end
		if (ctrl_r[CTRL_SF_BIT]) begin
			corr_w = corr_w - sf_w; // R8
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			comp_r <= '0;
		end else if (t2_r) begin
			comp_r <= corr_w[FIELD_W-1:0];
		end
	end

	// ****************************************
	// Accumulation and field formatting
	// ****************************************
	logic signed [SUM_W-1:0] gyro_sum_r, accel_sum_r, g_tot, a_tot;
	logic signed [ACC_W-1:0] angle_acc_r, ang_inc, angle_nxt;
	logic [CNT_W-1:0] cnt_r;
	logic last;

	assign g_tot = gyro_sum_r + SUM_W'(comp_r); // R3
	assign a_tot = accel_sum_r + SUM_W'(accel_in_r); // R12
	assign ang_inc = ACC_W'(comp_r) * ACC_W'($signed({1'b0, ANG_GAIN}));
	assign angle_nxt = angle_acc_r + ang_inc; // R16
	assign last = (cnt_r == CNT_W'((1 << log2n) - 1)); // R14

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			angle_acc_r <= '0;
		end else if (t3_r) begin
			angle_acc_r <= angle_nxt; // R6
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gyro_sum_r <= '0;
			accel_sum_r <= '0;
			cnt_r <= '0;
		end else if (t3_r) begin
			gyro_sum_r <= last ? '0 : g_tot;
			accel_sum_r <= last ? '0 : a_tot;
			cnt_r <= last ? '0 : cnt_r + 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gyro_field <= '0;
			accel_field <= '0;
			field_valid <= 1'b0;
		end else begin
			field_valid <= t3_r && last;
			if (t3_r && last) begin
				case (gunit)
					IMF_G_RATE: gyro_field <= comp_r; // R15
					IMF_G_INCR: gyro_field <= imf_scale(g_tot, ANG_GAIN); // R1
					IMF_G_AVG: gyro_field <= imf_avg(g_tot, log2n); // R5
					IMF_G_INTEG: gyro_field <= angle_nxt[ACC_W-1 -: FIELD_W]; // R7
					default: gyro_field <= comp_r;
				endcase
				case (aunit)
					IMF_A_VEL: accel_field <= imf_scale(a_tot, VEL_GAIN); // R11
					IMF_A_AVG: accel_field <= imf_avg(a_tot, log2n); // R13
					default: accel_field <= accel_in_r; // R10
				endcase
			end
		end
	end

	// ****************************************
	// Byte stream, gyro field then accel field
	// ****************************************
	imf_ser_e ser_r;
	logic [2*FIELD_W-1:0] frame_r;
	logic [2:0] idx_r;
	logic tx_hs;

	assign tx_hs = tx_valid && tx_ready;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ser_r <= IMF_SER_IDLE;
			frame_r <= '0;
			idx_r <= '0;
			tx_byte <= '0;
			tx_valid <= 1'b0;
			tx_first <= 1'b0;
		end else begin
			case (ser_r)
				IMF_SER_IDLE: begin
					if (field_valid) begin
						frame_r <= {gyro_field, accel_field};
						tx_byte <= gyro_field[FIELD_W-1 -: BYTE_W]; // R2
						tx_valid <= 1'b1;
						tx_first <= 1'b1;
						idx_r <= '0;
						ser_r <= IMF_SER_SEND;
					end
				end
				IMF_SER_SEND: begin
					if (tx_hs) begin
						idx_r <= idx_r + 1'b1;
						tx_byte <= imf_byte(frame_r, idx_r + 1'b1); // R2
						tx_first <= 1'b0;
						if (idx_r + 1'b1 == LAST_IDX) begin
							ser_r <= IMF_SER_LAST;
						end
					end
				end
				IMF_SER_LAST: begin
					if (tx_hs) begin
						tx_valid <= 1'b0;
						ser_r <= IMF_SER_IDLE;
					end
				end
				default: ser_r <= IMF_SER_IDLE;
			endcase
		end
	end

	// ****************************************
	// AXI4-Lite slave
	// ****************************************
	logic aw_held_r, w_held_r, do_write, wr_ok;
	logic [7:0] awaddr_r, wa, ra;
	logic [31:0] wdata_r, rd_word, strb_mask;
	logic [3:0] wstrb_r;
	logic ovr_clr, rd_ok;

	assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;
	assign wa = {awaddr_r[7:2], 2'h0};
	assign ra = {s_axi_araddr[7:2], 2'h0};
	assign wr_ok = (wa == REG_CTRL) || (wa == REG_GCOMP) || (wa == REG_STATUS);
	assign strb_mask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
	assign ovr_clr = do_write && (wa == REG_STATUS) && strb_mask[STAT_OVR_BIT] &&
		wdata_r[STAT_OVR_BIT];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			s_axi_awready <= 1'b1;
			awaddr_r <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_r <= 1'b1;
			s_axi_awready <= 1'b0;
			awaddr_r <= s_axi_awaddr;
		end else if (s_axi_bvalid && s_axi_bready) begin
			aw_held_r <= 1'b0;
			s_axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_r <= 1'b0;
			s_axi_wready <= 1'b1;
			wdata_r <= '0;
			wstrb_r <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_r <= 1'b1;
			s_axi_wready <= 1'b0;
			wdata_r <= s_axi_wdata;
			wstrb_r <= s_axi_wstrb;
		end else if (s_axi_bvalid && s_axi_bready) begin
			w_held_r <= 1'b0;
			s_axi_wready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r <= CTRL_RESET;
			gcomp_r <= GCOMP_RESET;
		end else if (do_write && wa == REG_CTRL) begin
			ctrl_r <= (ctrl_r & ~strb_mask) | (wdata_r & strb_mask);
		end else if (do_write && wa == REG_GCOMP) begin
			gcomp_r <= (gcomp_r & ~strb_mask) | (wdata_r & strb_mask);
		end
	end

	// Frame lost when a new one arrives during a send; set wins over clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ovr_r <= 1'b0;
		end else if (field_valid && ser_r != IMF_SER_IDLE) begin
			ovr_r <= 1'b1;
		end else if (ovr_clr) begin
			ovr_r <= 1'b0;
		end
	end

	always_comb begin
		rd_ok = 1'b1;
		rd_word = '0;
		case (ra)
			REG_CTRL: rd_word = ctrl_r;
			REG_GCOMP: rd_word = gcomp_r;
			REG_STATUS: begin
				rd_word[STAT_BUSY_BIT] = (ser_r != IMF_SER_IDLE);
				rd_word[STAT_OVR_BIT] = ovr_r;
			end
			REG_GYRO: rd_word = 32'(gyro_field);
			REG_ACCEL: rd_word = 32'(accel_field);
			default: rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	tick_spacing_a: assert property (sample_tick |=> !sample_tick[*2]) // R14
		else $error("sample tick repeated too soon");
	frame_count_a: assert property (field_valid |-> $past(cnt_r) == // R14
		CNT_W'((1 << $past(log2n)) - 1)) else $error("frame not after n samples");
	rate_field_a: assert property (field_valid && $past(gunit) == IMF_G_RATE |-> // R15
		gyro_field == $past(comp_r)) else $error("rate field not latest sample");
	incr_angle_a: assert property (field_valid && $past(gunit) == IMF_G_INCR |-> // R1
		gyro_field == imf_scale($past(g_tot), ANG_GAIN)) else $error("angle increment wrong");
	avg_rate_a: assert property (field_valid && $past(gunit) == IMF_G_AVG |-> // R3
		gyro_field == imf_avg($past(g_tot), $past(log2n))) else $error("average rate wrong");
	integ_wrap_a: assert property (t3_r |=> angle_acc_r == // R6
		$past(angle_acc_r) + $past(ang_inc)) else $error("angle integrator step wrong");
	integ_field_a: assert property (field_valid && $past(gunit) == IMF_G_INTEG |-> // R7
		gyro_field == angle_acc_r[ACC_W-1 -: FIELD_W]) else $error("integrated angle wrong");
	accel_field_a: assert property (field_valid && $past(aunit) == IMF_A_ACC |-> // R10
		accel_field == $past(accel_in_r)) else $error("acceleration field wrong");
	vel_incr_a: assert property (field_valid && $past(aunit) == IMF_A_VEL |-> // R11
		accel_field == imf_scale($past(a_tot), VEL_GAIN)) else $error("velocity wrong");
	avg_accel_a: assert property (field_valid && $past(aunit) == IMF_A_AVG |-> // R12
		accel_field == imf_avg($past(a_tot), $past(log2n))) else $error("average accel wrong");
	first_byte_a: assert property (field_valid && ser_r == IMF_SER_IDLE |=> // R2
		tx_valid && tx_first && tx_byte == frame_r[2*FIELD_W-1 -: BYTE_W])
		else $error("frame does not open with gyro high byte");

	frame_sent_c: cover property (tx_hs && ser_r == IMF_SER_LAST);
	avg_frame_c: cover property (field_valid && gunit == IMF_G_AVG && log2n == 3'h2);
	overrun_c: cover property (field_valid && ser_r != IMF_SER_IDLE);
	gcomp_on_c: cover property (t2_r && ctrl_r[CTRL_BIAS_BIT] && ctrl_r[CTRL_SF_BIT]);
endmodule : imf_formatter

// File: rtl/imf_lpf.sv
// Single-pole low-pass filter stepped once per internal sample
`timescale 1ns/10ps
module imf_lpf #(
	parameter int W = imf_pkg::FIELD_W,
	parameter int FRAC = imf_pkg::LPF_FRAC
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic en,
	input wire imf_pkg::imf_lpf_e sel,
	input wire logic signed [W-1:0] x,
	output logic signed [W-1:0] y
);
	import imf_pkg::*;

	logic signed [W+FRAC-1:0] state_r;
	logic signed [W+FRAC:0] diff;
	logic signed [W+FRAC-1:0] x_ext;

	assign x_ext = {x, {FRAC{1'b0}}};
	assign diff = (W+FRAC+1)'(x_ext) - (W+FRAC+1)'(state_r);
	assign y = state_r[W+FRAC-1 -: W];

	// ****************************************
	// Filter state, same latency when bypassed
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= '0;
		end else if (en) begin
			if (sel == IMF_LPF_OFF) begin
				state_r <= x_ext;
			end else begin
				state_r <= state_r + (W+FRAC)'(diff >>> imf_lpf_shift(sel)); // R9
			end
		end
	end
endmodule : imf_lpf

// File: rtl/imf_pkg.sv
// Constants, types and helpers shared by the output unit formatter
// Summary of operation
// R1: Incremental angle field, LSB 2^-21 degree
// R2: Fields sent MSB, mid, LSB; two's complement
// R3: Average rate is mean since last transmission
// R4: Gyro low-pass applied before averaging
// R5: Average rate scaled like plain rate
// R6: Integrated angle runs from reset, wraps silently
// R7: Integrated angle scaled like incremental angle
// R8: Optional g-compensation of gyro scale and bias
// R9: Optional one-pole filter on compensating accel
// R10: Acceleration field, LSB 2^-19 g
// R11: Incremental velocity field, LSB 2^-22 m/s
// R12: Average acceleration is mean since last transmission
// R13: Average acceleration scaled like acceleration
// R14: 2000 samples/s; n = 2000 / rate
// R15: Angular rate field, LSB 2^-14 deg/s
// R16: Integrators are wrapping accumulators cleared at reset
package imf_pkg;
	// ****************************************
	// Widths and arithmetic
	// ****************************************
	localparam int FIELD_W = 24;
	localparam int BYTE_W = 8;
	localparam int FRAME_BYTES = 6;
	localparam logic [2:0] LAST_IDX = 3'h5;
	localparam int LOG2N_W = 3;
	localparam logic [LOG2N_W-1:0] LOG2N_MAX = 3'h4;
	localparam int CNT_W = 4;
	localparam int SUM_W = 28;
	localparam int GAIN_W = 21;
	localparam int GAIN_FRAC = 24;
	localparam int ACC_W = FIELD_W + GAIN_FRAC;
	localparam int PROD_W = 64;
	localparam int COEF_W = 16;
	localparam int COEF_FRAC = 16;
	localparam int ONE_G_SHIFT = 19;
	localparam int LPF_FRAC = 20;
	localparam int LPF_SH_W = 5;

	// Rate LSB 2^-14 deg/s times 1/2000 s, in LSBs of 2^-21 deg
	localparam longint ANG_GAIN_L = ((64'sd1 <<< (GAIN_FRAC + 7)) + 1000) / 2000;
	localparam logic [GAIN_W-1:0] ANG_GAIN = GAIN_W'(ANG_GAIN_L);
	// Accel LSB 2^-19 g times 9.80665 m/s2/g / 2000, in LSBs of 2^-22 m/s
	localparam longint VEL_GAIN_L =
		((64'sd1 <<< (GAIN_FRAC + 3)) * 980665 + 100000000) / 200000000;
	localparam logic [GAIN_W-1:0] VEL_GAIN = GAIN_W'(VEL_GAIN_L);

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 8;
	localparam int INT_RATE_HZ = 2000;
	localparam int SAMPLE_PERIOD_NS = 1000000000 / INT_RATE_HZ;
	localparam int SAMPLE_DIV = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_GCOMP = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_GYRO = 8'h0c;
	localparam logic [7:0] REG_ACCEL = 8'h10;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] GCOMP_RESET = 32'h0000_0000;
	localparam int CTRL_GUNIT_LSB = 0;
	localparam int CTRL_AUNIT_LSB = 4;
	localparam int CTRL_LOG2N_LSB = 8;
	localparam int CTRL_GLPF_LSB = 12;
	localparam int CTRL_CLPF_LSB = 16;
	localparam int CTRL_BIAS_BIT = 20;
	localparam int CTRL_SF_BIT = 21;
	localparam int GCOMP_SF_LSB = 16;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_OVR_BIT = 1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		IMF_G_RATE = 2'h0, IMF_G_INCR = 2'h1, IMF_G_AVG = 2'h2, IMF_G_INTEG = 2'h3
	} imf_gunit_e;
	typedef enum logic [1:0] {
		IMF_A_ACC = 2'h0, IMF_A_VEL = 2'h1, IMF_A_AVG = 2'h2, IMF_A_RSVD = 2'h3
	} imf_aunit_e;
	typedef enum logic [1:0] {
		IMF_LPF_OFF = 2'h0, IMF_LPF_5HZ = 2'h1, IMF_LPF_0P01HZ = 2'h2, IMF_LPF_0P001HZ = 2'h3
	} imf_lpf_e;
	typedef enum logic [1:0] {
		IMF_SER_IDLE = 2'h0, IMF_SER_SEND = 2'h1, IMF_SER_LAST = 2'h3
	} imf_ser_e;

	localparam logic [LPF_SH_W-1:0] LPF_SH_5HZ = 5'h06;
	localparam logic [LPF_SH_W-1:0] LPF_SH_0P01HZ = 5'h0f;
	localparam logic [LPF_SH_W-1:0] LPF_SH_0P001HZ = 5'h12;

	// Filter coefficient as a right shift at the internal sample rate
	function automatic logic [LPF_SH_W-1:0] imf_lpf_shift(input imf_lpf_e sel);
		case (sel)
			IMF_LPF_5HZ: return LPF_SH_5HZ;
			IMF_LPF_0P01HZ: return LPF_SH_0P01HZ;
			IMF_LPF_0P001HZ: return LPF_SH_0P001HZ;
			default: return '0;
		endcase
	endfunction : imf_lpf_shift
endpackage : imf_pkg

// File: verif/imf_assembler_model.sv
// Datagram assembler model that collects six-byte frames from the byte stream
`timescale 1ns/10ps
module imf_assembler_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] tx_byte,
	input wire logic tx_valid,
	input wire logic tx_first,
	output logic tx_ready,
	input wire logic slow,
	output logic signed [23:0] frame_gyro,
	output logic signed [23:0] frame_accel,
	output logic [15:0] frame_cnt,
	output logic first_err
);
	logic [39:0] sh_r;
	logic [2:0] pos_r;
	logic ph_r;
	wire [47:0] word = {sh_r, tx_byte};
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sh_r <= '0;
			pos_r <= 3'h0;
			ph_r <= 1'b0;
			tx_ready <= 1'b0;
			frame_gyro <= '0;
			frame_accel <= '0;
			frame_cnt <= 16'h0;
			first_err <= 1'b0;
		end else begin
			ph_r <= ~ph_r;
			// Slow mode stalls every other cycle
			tx_ready <= ~slow | ph_r;
			if (tx_valid && tx_ready) begin
				sh_r <= word[39:0];
				first_err <= first_err | (tx_first !== (pos_r == 3'h0));
				if (pos_r == 3'h5) begin
					pos_r <= 3'h0;
					frame_gyro <= word[47:24];
					frame_accel <= word[23:0];
					frame_cnt <= frame_cnt + 16'h1;
				end else begin
					pos_r <= pos_r + 3'h1;
				end
			end
		end
	end
endmodule : imf_assembler_model

// File: verif/imf_output_unit_formatter_tb.sv
// Testbench for the output unit formatter
`timescale 1ns/10ps
module imf_output_unit_formatter_tb;
	import imf_pkg::*;
	localparam int DIV = 20;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = '0, araddr = '0, tx_byte;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = '0, rdata, rd;
	logic awready, wready, bvalid, arready, rvalid, sample_tick, field_valid;
	logic tx_valid, tx_first, tx_ready, first_err, slow = 1'b0, pat_on = 1'b0;
	logic [1:0] bresp, rresp, resp, idx = 2'h0;
	logic signed [FIELD_W-1:0] g_val = '0, a_val = '0, gyro_field, accel_field;
	logic signed [FIELD_W-1:0] frame_gyro, frame_accel, prev, delta;
	logic [15:0] frame_cnt;
	int err_count = 0, check_count = 0, t;
	int gexp [3] = '{7872, 7000, 6872};
	logic [31:0] gcs [3] = '{32'h0000_0010, 32'h2000_0000, 32'h2000_0010};
	// Period-four pattern: any four consecutive samples sum to 1001
	wire signed [FIELD_W-1:0] pv = (24'(idx) + 24'd1) * 24'd100 + 24'(idx == 2'h3);
	wire signed [FIELD_W-1:0] gyro_sample = pat_on ? pv : g_val;
	wire signed [FIELD_W-1:0] accel_sample = pat_on ? -pv : a_val;

	always #4 aclk = ~aclk;
	always @(posedge aclk) if (sample_tick) idx <= idx + 2'h1;

	imf_formatter #(.SAMPLE_DIV(DIV)) imf_formatter_i (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.gyro_sample(gyro_sample), .accel_sample(accel_sample), .sample_tick(sample_tick),
		.gyro_field(gyro_field), .accel_field(accel_field), .field_valid(field_valid),
		.tx_byte(tx_byte), .tx_valid(tx_valid), .tx_first(tx_first), .tx_ready(tx_ready));
	imf_assembler_model imf_assembler_model_i (.aclk(aclk), .aresetn(aresetn),
		.tx_byte(tx_byte), .tx_valid(tx_valid), .tx_first(tx_first), .tx_ready(tx_ready),
		.slow(slow), .frame_gyro(frame_gyro), .frame_accel(frame_accel),
		.frame_cnt(frame_cnt), .first_err(first_err));

	// ****************************************
	// Tasks
	// ****************************************
	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : end_of_test

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic timed_out(input string what);
		err_count++;
		$display("Error %s expected handshake seen timeout", what);
		end_of_test();
	endtask : timed_out

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int i = 0; i < 100; i++) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) begin
				r = bresp;
				bready <= 1'b0;
				return;
			end
		end
		timed_out("write");
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int i = 0; i < 100; i++) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				return;
			end
		end
		timed_out("read");
	endtask : axi_rd

	task automatic frames(input int k);
		logic [15:0] c0;
		c0 = frame_cnt;
		for (int i = 0; i < 4000 * k; i++) begin
			@(posedge aclk);
			if (frame_cnt == c0 + 16'(k)) return;
		end
		timed_out("frame");
	endtask : frames

	function automatic logic [31:0] cw(input logic [1:0] g, a, lp, input logic [2:0] n,
		input logic b, s);
		return {10'h0, s, b, 2'h0, lp, 5'h0, n, 2'h0, a, 2'h0, g};
	endfunction : cw

	task automatic cfg(input logic [31:0] ctrl_w, input logic [31:0] gc, input int k);
		axi_wr(REG_GCOMP, gc, resp);
		axi_wr(REG_CTRL, ctrl_w, resp);
		frames(k);
	endtask : cfg

	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		axi_rd(8'h20, rd, resp);
		check("unmapped rresp", 32'(resp), 32'(RESP_SLVERR));
		check("unmapped rdata", rd, 32'h0);
		a_val <= 24'sh080000;
		cfg(cw(IMF_G_RATE, IMF_A_ACC, IMF_LPF_5HZ, 3'h0, 1'b1, 1'b0), 32'h0000_4000, 2);
		check("filtered comp", 32'(frame_gyro > -24'sd65536), 32'h1);
		cfg(cw(IMF_G_RATE, IMF_A_ACC, IMF_LPF_OFF, 3'h0, 1'b1, 1'b0), 32'h0000_4000, 3);
		check("bias comp", 32'(frame_gyro), -32'sd131072);
		g_val <= 24'sd8000;
		for (int i = 0; i < 3; i++) begin
			cfg(cw(IMF_G_RATE, IMF_A_ACC, IMF_LPF_OFF, 3'h0, i != 1, i != 0), gcs[i], 3);
			check("g comp", 32'(frame_gyro), gexp[i]);
		end
		slow <= 1'b1;
		g_val <= 24'sh876543;
		a_val <= 24'sh123456;
		cfg(cw(IMF_G_RATE, IMF_A_ACC, IMF_LPF_OFF, 3'h0, 1'b0, 1'b0), 32'h0, 3);
		check("rate field", 32'(frame_gyro), 32'hff876543);
		check("accel field", 32'(frame_accel), 32'h00123456);
		axi_rd(REG_GYRO, rd, resp);
		check("gyro register", rd, 32'hff876543);
		check("gyro port", 32'(gyro_field), 32'hff876543);
		check("accel port", 32'(accel_field), 32'h00123456);
		axi_rd(REG_ACCEL, rd, resp);
		check("accel register", rd, 32'h00123456);
		slow <= 1'b0;
		g_val <= 24'sd15625;
		a_val <= 24'sh080000;
		cfg(cw(IMF_G_INCR, IMF_A_VEL, IMF_LPF_OFF, 3'h2, 1'b0, 1'b0), 32'h0, 3);
		check("angle increment", 32'(frame_gyro), 32'd4000);
		check("velocity increment", 32'(frame_accel), 32'd82264);
		pat_on <= 1'b1;
		cfg(cw(IMF_G_AVG, IMF_A_AVG, IMF_LPF_OFF, 3'h2, 1'b0, 1'b0), 32'h0, 3);
		check("average rate", 32'(frame_gyro), 32'd250);
		check("average accel", 32'(frame_accel), -32'sd251);
		for (int i = 0; i < 200 && !field_valid; i++) @(posedge aclk);
		t = 0;
		for (int i = 0; i < 200; i++) begin
			@(posedge aclk);
			t++;
			if (field_valid) break;
		end
		check("frame spacing", t, 4 * DIV);
		axi_rd(REG_STATUS, rd, resp);
		check("busy while sending", 32'(rd[STAT_BUSY_BIT]), 32'h1);
		pat_on <= 1'b0;
		g_val <= 24'sd8000000;
		cfg(cw(IMF_G_INTEG, IMF_A_ACC, IMF_LPF_OFF, 3'h0, 1'b0, 1'b0), 32'h0, 3);
		prev = frame_gyro;
		// Forty steps of 512000 wrap the field at least once
		for (int i = 0; i < 40; i++) begin
			frames(1);
			delta = frame_gyro - prev;
			check("integ step", 32'(delta == 24'sd512000 || delta == 24'sd512001), 1);
			prev = frame_gyro;
		end
		axi_rd(REG_STATUS, rd, resp);
		check("status after wrap", 32'(rd[STAT_OVR_BIT]), 32'h0);
		axi_wr(8'h20, 32'h1, resp);
		check("unmapped bresp", 32'(resp), 32'(RESP_SLVERR));
		check("first byte flag", 32'(first_err), 32'h0);
		aresetn <= 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		cfg(cw(IMF_G_INTEG, IMF_A_ACC, IMF_LPF_OFF, 3'h0, 1'b0, 1'b0), 32'h0, 1);
		check("integ after reset", 32'(frame_gyro), 32'd512000);
		end_of_test();
	end
endmodule : imf_output_unit_formatter_tb
